// [sarseq_pkg.sv]
// sarseq_pkg: constants and carrier types for the SAR conversion sequencer
// assumes a single core clock and a plain strobe-based register port
package sarseq_pkg;

    // ------------------------------------------------------------
    // register port
    // ------------------------------------------------------------
    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;

    localparam logic [3:0] OFF_CTRL   = 4'h0;
    localparam logic [3:0] OFF_CHAN   = 4'h1;
    localparam logic [3:0] OFF_RESULT = 4'h2;
    localparam logic [3:0] OFF_RES_HI = 4'h3;
    localparam logic [3:0] OFF_STATUS = 4'h4;
    localparam logic [3:0] OFF_MASK   = 4'h5;

    localparam logic [7:0] CTRL_RST   = 8'h00;
    localparam logic [4:0] CHAN_RST   = 5'h00;
    localparam logic [0:0] STATUS_RST = 1'h0;
    localparam logic [0:0] MASK_RST   = 1'h0;
    localparam int         STATUS_DONE_BIT = 0;

    // ------------------------------------------------------------
    // channels and timing
    // ------------------------------------------------------------
    localparam logic [4:0] CHAN_GROUP0_LAST = 5'h0e;
    localparam logic [4:0] CHAN_SKIPPED     = 5'h0f;
    localparam logic [4:0] CHAN_GROUP1_LAST = 5'h14;
    localparam logic [4:0] SCAN_BASE_MAX    = 5'h0b;
    localparam logic [1:0] SCAN_LAST_STEP   = 2'h3;
    localparam logic [2:0] SAMPLE_CYC_SPD0  = 3'h7;
    localparam logic [2:0] SAMPLE_CYC_SPD1  = 3'h5;
    localparam logic [3:0] MSB_IDX          = 4'h9;
    localparam logic [3:0] LSB_IDX_10BIT    = 4'h0;
    localparam logic [3:0] LSB_IDX_8BIT     = 4'h2;
    localparam int         RESULT_SHIFT     = 6;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef struct packed {
        logic standby_en;
        logic speed;
        logic ref_ext;
        logic res8;
        logic hw_trig;
        logic seq;
        logic scan;
        logic run;
    } sarseq_ctrl_t;

    typedef struct packed {
        logic [4:0] chan;
        logic       sample;
        logic       ref_ext;
        logic [9:0] trial;
    } sarseq_ana_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SAMPLE,
        ST_CONVERT,
        ST_DONE
    } sarseq_state_t;

endpackage

// [sarseq_top.sv]
// sarseq_top: sequencer for a 10-bit successive-approximation converter
// assumes comparator output is valid in the same cycle the trial code moves
//
// The plain strobed port and the address map were chosen for this implementation.
`timescale 1ns/1ps

// What this block does
// - route one of 20 inputs, 0..14 and 16..20, to sample-and-hold
// - select mode converts the one channel chosen in the channel register
// - scan mode converts four consecutive channels within inputs 0..14
// - every finished conversion, scan steps included, raises done interrupt
// - conversion starts by software write or by the hardware trigger
// - one-shot runs one pass; sequential repeats passes continuously
// - result word holds the 10-bit result in its upper ten bits
// - high-byte register shows the top eight result bits
// - a control bit picks 8-bit or 10-bit resolution
// - in stop mode a hardware trigger wakes and converts without cpu
// - reference select picks supply pair or dedicated reference pins
// - one-shot end clears run bit; software may clear it too
// - sampling lasts 7 cycles at first speed, 5 at second
module sarseq_top #(
    parameter int CHAN_W = 5
) (
    // clock and reset
    input  wire logic                      core_clk_i,
    input  wire logic                      rst_i,
    // register port
    input  wire logic [sarseq_pkg::ADDR_W-1:0] addr_i,
    input  wire logic [sarseq_pkg::DATA_W-1:0] wdata_i,
    input  wire logic                      wr_i,
    input  wire logic                      rd_i,
    output logic [sarseq_pkg::DATA_W-1:0]  rdata_o,
    // system
    input  wire logic                      converter_clock_enable_i,
    input  wire logic                      hw_trigger_i,
    input  wire logic                      stop_mode_i,
    output logic                           stop_release_o,
    output logic                           conversion_done_irq_o,
    // analog front end
    input  wire logic                      cmp_i,
    output sarseq_pkg::sarseq_ana_t        ana_o
);

    // channel decode and refusal compares are written for five bits
    if (CHAN_W != 5) begin : g_chan_w_check
        $error("sarseq_top: CHAN_W must be 5");
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    sarseq_pkg::sarseq_ctrl_t  ctrl_reg;
    sarseq_pkg::sarseq_state_t state_reg;
    logic [CHAN_W-1:0]         chan_reg;
    logic [CHAN_W-1:0]         base_reg;
    logic [1:0]                step_reg;
    logic [2:0]                samp_cnt_reg;
    logic [3:0]                bit_idx_reg;
    logic [9:0]                trial_reg;
    logic [9:0]                trial_next;
    logic [9:0]                result_reg;
    logic [0:0]                status_reg;
    logic [0:0]                mask_reg;
    logic [CHAN_W-1:0]         cur_chan;
    logic [3:0]                lsb_idx;
    logic [2:0]                samp_len;
    logic                      start;
    logic                      pass_last;
    logic                      wr_ctrl;
    logic                      done_evt;

    assign wr_ctrl   = wr_i && (addr_i == sarseq_pkg::OFF_CTRL);
    assign lsb_idx   = ctrl_reg.res8 ? sarseq_pkg::LSB_IDX_8BIT
                                     : sarseq_pkg::LSB_IDX_10BIT;
    assign samp_len  = ctrl_reg.speed ? sarseq_pkg::SAMPLE_CYC_SPD1
                                      : sarseq_pkg::SAMPLE_CYC_SPD0;
    // a start needs the clock enable; hardware mode waits for the pulse
    assign start     = ctrl_reg.run && converter_clock_enable_i
                       && (!ctrl_reg.hw_trig || hw_trigger_i);
    assign pass_last = !ctrl_reg.scan
                       || (step_reg == sarseq_pkg::SCAN_LAST_STEP);
    assign done_evt  = (state_reg == sarseq_pkg::ST_DONE);
    assign cur_chan  = ctrl_reg.scan ? base_reg + {3'h0, step_reg}
                                     : base_reg;

    // ------------------------------------------------------------
    // control and channel registers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            ctrl_reg <= sarseq_pkg::sarseq_ctrl_t'(sarseq_pkg::CTRL_RST);
        end else if (wr_ctrl) begin
            ctrl_reg <= sarseq_pkg::sarseq_ctrl_t'(wdata_i[7:0]);
        end else if (done_evt && pass_last && !ctrl_reg.seq) begin
            ctrl_reg.run <= 1'b0;
        end
    end

    // the skipped index and anything past the last input are refused
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            chan_reg <= sarseq_pkg::CHAN_RST;
        end else if (wr_i && (addr_i == sarseq_pkg::OFF_CHAN)
                     && (wdata_i[4:0] != sarseq_pkg::CHAN_SKIPPED)
                     && (wdata_i[4:0] <= sarseq_pkg::CHAN_GROUP1_LAST)) begin
            chan_reg <= wdata_i[4:0];
        end
    end

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    always_comb begin
        trial_next = trial_reg;
        if (!cmp_i) begin
            trial_next[bit_idx_reg] = 1'b0;
        end
        if (bit_idx_reg > lsb_idx) begin
            trial_next[bit_idx_reg - 4'h1] = 1'b1;
        end
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_reg <= sarseq_pkg::ST_IDLE;
        end else if (!ctrl_reg.run || !converter_clock_enable_i) begin
            state_reg <= sarseq_pkg::ST_IDLE;
        end else begin
            unique case (state_reg)
                sarseq_pkg::ST_IDLE: begin
                    if (start) begin
                        state_reg <= sarseq_pkg::ST_SAMPLE;
                    end
                end
                sarseq_pkg::ST_SAMPLE: begin
                    if (samp_cnt_reg == samp_len - 3'h1) begin
                        state_reg <= sarseq_pkg::ST_CONVERT;
                    end
                end
                sarseq_pkg::ST_CONVERT: begin
                    if (bit_idx_reg == lsb_idx) begin
                        state_reg <= sarseq_pkg::ST_DONE;
                    end
                end
                sarseq_pkg::ST_DONE: begin
                    if (!pass_last || ctrl_reg.seq) begin
                        state_reg <= sarseq_pkg::ST_SAMPLE;
                    end else begin
                        state_reg <= sarseq_pkg::ST_IDLE;
                    end
                end
            endcase
        end
    end

    // scan base is clamped so all four channels stay in the first group
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            base_reg <= sarseq_pkg::CHAN_RST;
            step_reg <= 2'h0;
        end else if (state_reg == sarseq_pkg::ST_IDLE) begin
            step_reg <= 2'h0;
            if (ctrl_reg.scan && (chan_reg > sarseq_pkg::SCAN_BASE_MAX)) begin
                base_reg <= sarseq_pkg::SCAN_BASE_MAX;
            end else begin
                base_reg <= chan_reg;
            end
        end else if (done_evt && ctrl_reg.scan) begin
            step_reg <= step_reg + 2'h1;
        end
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            samp_cnt_reg <= 3'h0;
        end else if (state_reg == sarseq_pkg::ST_SAMPLE) begin
            samp_cnt_reg <= samp_cnt_reg + 3'h1;
        end else begin
            samp_cnt_reg <= 3'h0;
        end
    end

    // one trial bit per cycle, msb first
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            trial_reg   <= 10'h000;
            bit_idx_reg <= sarseq_pkg::MSB_IDX;
        end else if (state_reg == sarseq_pkg::ST_CONVERT) begin
            trial_reg   <= trial_next;
            bit_idx_reg <= bit_idx_reg - 4'h1;
        end else begin
            trial_reg   <= 10'h200;
            bit_idx_reg <= sarseq_pkg::MSB_IDX;
        end
    end

    // only a finished code is stored, never a partial one
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            result_reg <= 10'h000;
        end else if (state_reg == sarseq_pkg::ST_CONVERT
                     && bit_idx_reg == lsb_idx) begin
            result_reg <= trial_next;
        end
    end

    // ------------------------------------------------------------
    // interrupt
    // ------------------------------------------------------------
    // set wins over a write-one clear in the same cycle
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            status_reg <= sarseq_pkg::STATUS_RST;
        end else begin
            status_reg <= (status_reg
                           & ~((wr_i && addr_i == sarseq_pkg::OFF_STATUS)
                               ? wdata_i[0:0] : 1'b0))
                          | done_evt;
        end
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            mask_reg <= sarseq_pkg::MASK_RST;
        end else if (wr_i && addr_i == sarseq_pkg::OFF_MASK) begin
            mask_reg <= wdata_i[0:0];
        end
    end

    assign conversion_done_irq_o = |(status_reg & mask_reg);

    // ------------------------------------------------------------
    // read port
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_o <= 16'h0000;
        end else if (rd_i) begin
            unique case (addr_i)
                sarseq_pkg::OFF_CTRL:   rdata_o <= {8'h00, ctrl_reg};
                sarseq_pkg::OFF_CHAN:   rdata_o <= {11'h000, chan_reg};
                sarseq_pkg::OFF_RESULT:
                    rdata_o <= {result_reg, 6'h00};
                sarseq_pkg::OFF_RES_HI:
                    rdata_o <= {8'h00, result_reg[9:2]};
                sarseq_pkg::OFF_STATUS: rdata_o <= {15'h0000, status_reg};
                sarseq_pkg::OFF_MASK:   rdata_o <= {15'h0000, mask_reg};
                default:                rdata_o <= 16'h0000;
            endcase
        end else begin
            rdata_o <= 16'h0000;
        end
    end

    // ------------------------------------------------------------
    // analog and system outputs
    // ------------------------------------------------------------
    always_comb begin
        ana_o.chan    = cur_chan;
        ana_o.sample  = (state_reg == sarseq_pkg::ST_SAMPLE);
        ana_o.ref_ext = ctrl_reg.ref_ext;
        ana_o.trial   = trial_reg;
    end

    // held for the whole standby conversion so the cpu stays asleep
    // until the sequencer is back in idle after the done state
    assign stop_release_o = stop_mode_i && ctrl_reg.standby_en
                            && ctrl_reg.hw_trig
                            && ((state_reg != sarseq_pkg::ST_IDLE)
                                || start);

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);

    AST_CHAN_LEGAL: assert property (
        ana_o.sample |-> (ana_o.chan != sarseq_pkg::CHAN_SKIPPED)
                         && (ana_o.chan <= sarseq_pkg::CHAN_GROUP1_LAST))
        else $error("illegal channel sampled");
    AST_SELECT_CHAN: assert property (
        (state_reg == sarseq_pkg::ST_IDLE) && start && !ctrl_reg.scan
        |=> ana_o.chan == $past(chan_reg))
        else $error("select mode channel mismatch");
    AST_SCAN_GROUP: assert property (
        ana_o.sample && ctrl_reg.scan
        |-> ana_o.chan <= sarseq_pkg::CHAN_GROUP0_LAST)
        else $error("scan left first group");
    AST_DONE_IRQ: assert property (
        done_evt |=> status_reg[sarseq_pkg::STATUS_DONE_BIT])
        else $error("done flag not set");
    AST_HW_START: assert property (
        (state_reg == sarseq_pkg::ST_IDLE) && ctrl_reg.run
        && ctrl_reg.hw_trig && converter_clock_enable_i && !hw_trigger_i
        && !wr_ctrl |=> state_reg == sarseq_pkg::ST_IDLE)
        else $error("hardware mode started without trigger");
    AST_SEQ_REPEAT: assert property (
        done_evt && ctrl_reg.seq && ctrl_reg.run && !wr_ctrl
        && converter_clock_enable_i
        |=> state_reg == sarseq_pkg::ST_SAMPLE)
        else $error("sequential pass did not repeat");
    AST_RES_WORD: assert property (
        rd_i && addr_i == sarseq_pkg::OFF_RESULT
        |=> rdata_o == {$past(result_reg), 6'h00})
        else $error("result word misaligned");
    AST_RES_HIGH: assert property (
        rd_i && addr_i == sarseq_pkg::OFF_RES_HI
        |=> rdata_o == {8'h00, $past(result_reg[9:2])})
        else $error("high byte wrong");
    AST_RES8_ZERO: assert property (
        done_evt && ctrl_reg.res8 |-> result_reg[1:0] == 2'h0)
        else $error("8-bit result has low bits");
    AST_WAKE: assert property (
        stop_mode_i && ctrl_reg.standby_en && ctrl_reg.hw_trig
        && ana_o.sample |-> stop_release_o)
        else $error("stop not released");
    AST_ONESHOT_CLR: assert property (
        done_evt && pass_last && !ctrl_reg.seq && !wr_ctrl
        |=> !ctrl_reg.run ##1 state_reg == sarseq_pkg::ST_IDLE)
        else $error("one-shot run bit not cleared");
    // judged at the hand-over to convert, so a software abort stays legal
    AST_SAMPLE7: assert property (
        $fell(ana_o.sample) && (state_reg == sarseq_pkg::ST_CONVERT)
        && !ctrl_reg.speed
        |-> $past(ana_o.sample, 7) && !$past(ana_o.sample, 8))
        else $error("sampling not seven cycles");
    AST_SAMPLE5: assert property (
        $fell(ana_o.sample) && (state_reg == sarseq_pkg::ST_CONVERT)
        && ctrl_reg.speed
        |-> $past(ana_o.sample, 5) && !$past(ana_o.sample, 6))
        else $error("sampling not five cycles");
    AST_RES_STABLE: assert property (
        !(state_reg == sarseq_pkg::ST_CONVERT && bit_idx_reg == lsb_idx)
        |=> $stable(result_reg))
        else $error("result moved mid conversion");
    AST_SCAN_WRAP: assert property (
        done_evt && ctrl_reg.scan && step_reg == sarseq_pkg::SCAN_LAST_STEP
        |=> step_reg == 2'h0)
        else $error("scan did not wrap");

    COV_SELECT: cover property (done_evt && !ctrl_reg.scan);
    COV_SCAN_WRAP: cover property (done_evt && ctrl_reg.scan && pass_last);
    COV_HW_WAKE: cover property ($rose(stop_release_o));
    COV_IRQ: cover property ($rose(conversion_done_irq_o));

endmodule // sarseq_top

// [sarseq_afe_model.sv]
// sarseq_afe_model: analog mux, sample-and-hold and comparator stand-in
// assumes ana_i comes straight from sarseq_top; cmp_o is combinational
`timescale 1ns/1ps

module sarseq_afe_model (
    // analog control from the sequencer
    input  wire sarseq_pkg::sarseq_ana_t ana_i,
    // comparator answer
    output logic                         cmp_o
);
    // ------------------------------------------------------------
    // per-channel input level and comparison
    // ------------------------------------------------------------
    logic [9:0] level;

    // level depends on channel and on the reference pair in use
    always_comb begin
        level = 10'(ana_i.chan) * 10'h02f + 10'h00d;
        if (ana_i.ref_ext)
            level = level ^ 10'h155;
        cmp_o = (level >= ana_i.trial);
    end
endmodule // sarseq_afe_model

// [testbench.sv]
// testbench: random and corner-case run of the conversion sequencer
// assumes sarseq_top and sarseq_afe_model; one 25 MHz clock
`timescale 1ns/1ps

module testbench;
    logic                    core_clk_i, rst_i, wr_i, rd_i;
    logic                    clk_en, trig, stop_m, cmp, stop_rel, irq;
    logic [3:0]              addr;
    logic [15:0]             wdata, rdata, d, prev;
    sarseq_pkg::sarseq_ana_t ana;
    logic [31:0]             r;
    logic [4:0]              ch, b, e;
    logic [4:0]              chq[$];
    int                      seed = 73973;
    int                      n_mismatch = 0;
    int                      num_checks = 0;
    int                      scnt = 0;
    int                      slen, i, j, k, n;

    sarseq_top sarseq_top_inst (.core_clk_i(core_clk_i), .rst_i(rst_i),
        .addr_i(addr), .wdata_i(wdata), .wr_i(wr_i), .rd_i(rd_i),
        .rdata_o(rdata), .converter_clock_enable_i(clk_en),
        .hw_trigger_i(trig), .stop_mode_i(stop_m),
        .stop_release_o(stop_rel), .conversion_done_irq_o(irq),
        .cmp_i(cmp), .ana_o(ana));
    sarseq_afe_model sarseq_afe_model_inst (.ana_i(ana), .cmp_o(cmp));

    // ------------------------------------------------------------
    // clock, monitor, helpers
    // ------------------------------------------------------------
    initial begin
        core_clk_i = 1'b0;
        forever #20 core_clk_i = ~core_clk_i;
    end

    // logs channel and length of each sample phase
    always @(negedge core_clk_i) begin
        if (ana.sample === 1'b1) begin
            if (scnt == 0)
                chq.push_back(ana.chan);
            scnt++;
        end else if (scnt != 0) begin
            slen = scnt;
            scnt = 0;
        end
    end

    function automatic logic [9:0] lvl(input logic [4:0] c, input logic x);
        lvl = (10'(c) * 10'h02f + 10'h00d) ^ (x ? 10'h155 : 10'h000);
    endfunction

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] v);
        @(posedge core_clk_i);
        wr_i  <= 1'b1;
        addr  <= a;
        wdata <= v;
        @(posedge core_clk_i);
        wr_i  <= 1'b0;
    endtask

    // read data stands only in the cycle after the strobe
    task automatic rd(input logic [3:0] a);
        @(posedge core_clk_i);
        rd_i <= 1'b1;
        addr <= a;
        @(posedge core_clk_i);
        rd_i <= 1'b0;
        @(negedge core_clk_i);
        d = rdata;
    endtask

    task automatic wait_irq();
        for (int t = 0; t < 300 && irq !== 1'b1; t++)
            @(negedge core_clk_i);
        check(16'(irq), 16'h0001);
    endtask

    // one select-mode one-shot conversion, status left set at the end
    task automatic conv(input logic [4:0] c, input logic [7:0] m);
        logic [9:0]  l;
        logic [15:0] w;
        l = lvl(c, m[5]);
        w = m[4] ? {l[9:2], 8'h00} : {l, 6'h00};
        wr(sarseq_pkg::OFF_STATUS, 16'h0001);
        chq.delete();
        wr(sarseq_pkg::OFF_CHAN, {11'h000, c});
        wr(sarseq_pkg::OFF_CTRL, {8'h00, m});
        repeat (8) @(negedge core_clk_i);
        rd(sarseq_pkg::OFF_RESULT);
        check(d, prev);
        wait_irq();
        check(16'(chq.size()), 16'h0001);
        check(16'(chq[0]), 16'(c));
        check(16'(slen), m[6] ? 16'h0005 : 16'h0007);
        rd(sarseq_pkg::OFF_RESULT);
        check(d, w);
        prev = w;
        rd(sarseq_pkg::OFF_RES_HI);
        check(d, {8'h00, l[9:2]});
        rd(sarseq_pkg::OFF_CTRL);
        check(d, {8'h00, m & 8'hfe});
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // run needs well under 20k cycles
    initial begin
        #(40 * 30000);
        n_mismatch++;
        end_of_test();
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        rst_i  = 1'b1;
        wr_i   = 1'b0;
        rd_i   = 1'b0;
        addr   = 4'h0;
        wdata  = 16'h0000;
        clk_en = 1'b1;
        trig   = 1'b0;
        stop_m = 1'b0;
        repeat (16) @(posedge core_clk_i);
        rst_i <= 1'b0;
        rd(sarseq_pkg::OFF_CTRL);
        check(d, 16'h0000);
        rd(sarseq_pkg::OFF_MASK);
        check(d, 16'h0000);
        rd(4'h9);
        check(d, 16'h0000);
        rd(sarseq_pkg::OFF_RESULT);
        prev = d;
        wr(sarseq_pkg::OFF_MASK, 16'h0001);
        for (i = 0; i < 8; i++) begin
            r  = $random(seed);
            ch = 5'(r % 32'd20);
            if (ch >= 5'h0f)
                ch++;
            conv(ch, {1'b0, r[8], r[9], r[10], 4'h1});
        end
        $display("test select done");
        // interrupt masking on a set status bit
        wr(sarseq_pkg::OFF_MASK, 16'h0000);
        @(negedge core_clk_i);
        check(16'(irq), 16'h0000);
        rd(sarseq_pkg::OFF_STATUS);
        check(d, 16'h0001);
        wr(sarseq_pkg::OFF_MASK, 16'h0001);
        @(negedge core_clk_i);
        check(16'(irq), 16'h0001);
        wr(sarseq_pkg::OFF_CHAN, 16'h0004);
        foreach (chq[q]) chq[q] = 5'h00;
        for (k = 0; k < 3; k++) begin
            wr(sarseq_pkg::OFF_CHAN, k == 0 ? 16'h000f : 16'h0014 + 16'(k));
            rd(sarseq_pkg::OFF_CHAN);
            check(d, 16'h0004);
        end
        $display("test mask and channel done");
        for (j = 0; j < 2; j++) begin
            b = (j == 0) ? 5'h05 : 5'h0d;
            e = (j == 0) ? 5'h05 : 5'h0b;
            wr(sarseq_pkg::OFF_STATUS, 16'h0001);
            chq.delete();
            wr(sarseq_pkg::OFF_CHAN, {11'h000, b});
            wr(sarseq_pkg::OFF_CTRL, 16'h0003);
            for (k = 0; k < 4; k++) begin
                wait_irq();
                wr(sarseq_pkg::OFF_STATUS, 16'h0001);
                @(negedge core_clk_i);
                check(16'(irq), 16'h0000);
            end
            repeat (30) @(negedge core_clk_i);
            check(16'(chq.size()), 16'h0004);
            for (k = 0; k < 4; k++)
                check(16'(chq[k]), 16'(e) + 16'(k));
            rd(sarseq_pkg::OFF_CTRL);
            check(d, 16'h0002);
        end
        $display("test scan done");
        chq.delete();
        wr(sarseq_pkg::OFF_CHAN, 16'h0003);
        wr(sarseq_pkg::OFF_CTRL, 16'h0005);
        for (k = 0; k < 300 && chq.size() < 3; k++)
            @(negedge core_clk_i);
        wr(sarseq_pkg::OFF_CTRL, 16'h0000);
        repeat (40) @(negedge core_clk_i);
        n = chq.size();
        repeat (60) @(negedge core_clk_i);
        check(16'(n >= 3), 16'h0001);
        check(16'(chq.size()), 16'(n));
        rd(sarseq_pkg::OFF_CTRL);
        check(d, 16'h0000);
        $display("test sequential done");
        wr(sarseq_pkg::OFF_STATUS, 16'h0001);
        chq.delete();
        stop_m <= 1'b1;
        wr(sarseq_pkg::OFF_CHAN, 16'h0002);
        wr(sarseq_pkg::OFF_CTRL, 16'h0089);
        repeat (30) @(negedge core_clk_i);
        check(16'(chq.size()), 16'h0000);
        check(16'(stop_rel), 16'h0000);
        @(posedge core_clk_i);
        trig <= 1'b1;
        @(negedge core_clk_i);
        check(16'(stop_rel), 16'h0001);
        @(posedge core_clk_i);
        trig <= 1'b0;
        wait_irq();
        check(16'(chq[0]), 16'h0002);
        rd(sarseq_pkg::OFF_RESULT);
        check(d, {lvl(5'h02, 1'b0), 6'h00});
        rd(sarseq_pkg::OFF_CTRL);
        check(d, 16'h0088);
        @(posedge core_clk_i);
        stop_m <= 1'b0;
        $display("test trigger done");
        // starts with the converter clock off are ignored
        clk_en <= 1'b0;
        wr(sarseq_pkg::OFF_STATUS, 16'h0001);
        chq.delete();
        wr(sarseq_pkg::OFF_CTRL, 16'h0001);
        repeat (60) @(negedge core_clk_i);
        check(16'(chq.size()), 16'h0000);
        check(16'(irq), 16'h0000);
        wr(sarseq_pkg::OFF_CTRL, 16'h0000);
        clk_en <= 1'b1;
        $display("test enable done");
        end_of_test();
    end
endmodule // testbench
